// [verilog/osc_top.sv]
// Output state control for cable and trace drivers with APB registers
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module osc_top (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                loss_of_signal,
    input  wire logic                rate_search,
    input  wire logic                trace_locked,
    input  wire logic                sleep,
    input  wire logic                cable_mode,
    output osc_pkg::osc_state_t      cable_state_ff,
    output osc_pkg::osc_state_t      trace_state_ff,
    output logic                     trace_loopback_ff,
    output logic                     loop_reclock_ff
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [5:0]          mute_ff;
    logic [3:0]          dis_ff;
    logic                cable_output_balance_ff;
    logic                trace_sleep_mute_ff;
    logic                trace_loopback_enable_ff;
    logic                idle_trace_mute_select_ff;
    osc_pkg::osc_stat_t  st;
    osc_pkg::osc_ctrl_t  ctrl0;
    osc_pkg::osc_ctrl_t  ctrl1;
    osc_pkg::osc_state_t base0;
    osc_pkg::osc_state_t base1;
    osc_pkg::osc_state_t nxt_cable;
    osc_pkg::osc_state_t nxt_trace;
    logic                nxt_loop;
    logic                nxt_reclock;
    logic                loop_active;
    logic                wr_en;
    logic                rd_en;
    logic                hit;
    logic [31:0]         rd_mux;

    // ------------------------------------------------------------
    // Status synchronisers
    // ------------------------------------------------------------
    osc_sync u_s_los  (.clk_sys(clk_sys), .rst_n(rst_n), .din(loss_of_signal), .dout(st.loss_of_signal));
    osc_sync u_s_rate (.clk_sys(clk_sys), .rst_n(rst_n), .din(rate_search),    .dout(st.rate_search));
    osc_sync u_s_lock (.clk_sys(clk_sys), .rst_n(rst_n), .din(trace_locked),   .dout(st.trace_locked));
    osc_sync u_s_slp  (.clk_sys(clk_sys), .rst_n(rst_n), .din(sleep),          .dout(st.sleep));
    osc_sync u_s_mode (.clk_sys(clk_sys), .rst_n(rst_n), .din(cable_mode),     .dout(st.cable_mode));

    // ------------------------------------------------------------
    // APB decode, single-cycle access phase
    // ------------------------------------------------------------
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign hit   = (paddr == osc_pkg::OSC_ADDR_MUTE)    | (paddr == osc_pkg::OSC_ADDR_DISABLE) |
                   (paddr == osc_pkg::OSC_ADDR_BALANCE) | (paddr == osc_pkg::OSC_ADDR_SLEEP) |
                   (paddr == osc_pkg::OSC_ADDR_LOOP)    | (paddr == osc_pkg::OSC_ADDR_STATUS);
    // Read data selection
    assign rd_mux = (paddr == osc_pkg::OSC_ADDR_MUTE)    ? {26'h0, mute_ff} :
                    (paddr == osc_pkg::OSC_ADDR_DISABLE) ? {28'h0, dis_ff} :
                    (paddr == osc_pkg::OSC_ADDR_BALANCE) ? {31'h0, cable_output_balance_ff} :
                    (paddr == osc_pkg::OSC_ADDR_SLEEP)   ? {31'h0, trace_sleep_mute_ff} :
                    (paddr == osc_pkg::OSC_ADDR_LOOP)    ? {30'h0, idle_trace_mute_select_ff,
                                                            trace_loopback_enable_ff} :
                    (paddr == osc_pkg::OSC_ADDR_STATUS)  ? {21'h0, loop_reclock_ff, trace_loopback_ff,
                                                            trace_state_ff, cable_state_ff, st} :
                    32'h0;

    // Bus response registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : prdata;
        end
    end

    // Control register writes, taken at the pready edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mute_ff                   <= osc_pkg::OSC_RST_MUTE;
            dis_ff                    <= osc_pkg::OSC_RST_DISABLE;
            cable_output_balance_ff   <= osc_pkg::OSC_RST_BAL;
            trace_sleep_mute_ff       <= osc_pkg::OSC_RST_SLPMUTE;
            trace_loopback_enable_ff  <= osc_pkg::OSC_RST_LOOP[osc_pkg::OSC_B_LOOP_ENA];
            idle_trace_mute_select_ff <= osc_pkg::OSC_RST_LOOP[osc_pkg::OSC_B_IDLE_MUTE];
        end else if (wr_en & pready) begin
            if (paddr == osc_pkg::OSC_ADDR_MUTE)
                mute_ff <= pwdata[5:0];
            if (paddr == osc_pkg::OSC_ADDR_DISABLE)
                dis_ff <= pwdata[3:0];
            if (paddr == osc_pkg::OSC_ADDR_BALANCE)
                cable_output_balance_ff <= pwdata[osc_pkg::OSC_B_BALANCE];
            if (paddr == osc_pkg::OSC_ADDR_SLEEP)
                trace_sleep_mute_ff <= pwdata[osc_pkg::OSC_B_SLEEP_MUTE];
            if (paddr == osc_pkg::OSC_ADDR_LOOP) begin
                trace_loopback_enable_ff  <= pwdata[osc_pkg::OSC_B_LOOP_ENA];
                idle_trace_mute_select_ff <= pwdata[osc_pkg::OSC_B_IDLE_MUTE];
            end
        end
    end

    // ------------------------------------------------------------
    // Per-output mute and disable
    // ------------------------------------------------------------
    assign ctrl0 = '{auto_mute: mute_ff[osc_pkg::OSC_B_AUTO_MUTE], rate_mute: mute_ff[osc_pkg::OSC_B_RATE_MUTE],
                     man_mute: mute_ff[osc_pkg::OSC_B_MAN_MUTE], auto_dis: dis_ff[osc_pkg::OSC_B_AUTO_DIS],
                     man_dis: dis_ff[osc_pkg::OSC_B_MAN_DIS]};
    assign ctrl1 = '{auto_mute: mute_ff[osc_pkg::OSC_B_AUTO_MUTE+1], rate_mute: mute_ff[osc_pkg::OSC_B_RATE_MUTE+1],
                     man_mute: mute_ff[osc_pkg::OSC_B_MAN_MUTE+1], auto_dis: dis_ff[osc_pkg::OSC_B_AUTO_DIS+1],
                     man_dis: dis_ff[osc_pkg::OSC_B_MAN_DIS+1]};

    osc_mode u_mode0 (.ctrl(ctrl0), .loss_of_signal(st.loss_of_signal), .rate_search(st.rate_search),
                      .state(base0));
    osc_mode u_mode1 (.ctrl(ctrl1), .loss_of_signal(st.loss_of_signal), .rate_search(st.rate_search),
                      .state(base1));

    // ------------------------------------------------------------
    // Final state selection
    // ------------------------------------------------------------
    // Loopback only in cable mode and only when trace not held off
    assign loop_active = st.cable_mode & trace_loopback_enable_ff & (base1 == osc_pkg::OSC_OPERATE);

    // Cable: sleep, then balance, then mute and disable
    assign nxt_cable = st.sleep ? osc_pkg::OSC_DISABLED :
                       cable_output_balance_ff ? osc_pkg::OSC_BALANCED :
                       base0;

    // Trace: sleep, base controls, loopback, idle cable-mode select
    assign nxt_trace = st.sleep ? (trace_sleep_mute_ff ? osc_pkg::OSC_MUTED : osc_pkg::OSC_DISABLED) :
                       (base1 != osc_pkg::OSC_OPERATE) ? base1 :
                       loop_active ? osc_pkg::OSC_OPERATE :
                       st.cable_mode ? (idle_trace_mute_select_ff ? osc_pkg::OSC_MUTED
                                                                  : osc_pkg::OSC_DISABLED) :
                       osc_pkg::OSC_OPERATE;
    assign nxt_loop    = ~st.sleep & loop_active;
    assign nxt_reclock = nxt_loop & st.trace_locked;

    // Output state registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cable_state_ff    <= osc_pkg::OSC_OPERATE;
            trace_state_ff    <= osc_pkg::OSC_OPERATE;
            trace_loopback_ff <= 1'b0;
            loop_reclock_ff   <= 1'b0;
        end else begin
            cable_state_ff    <= nxt_cable;
            trace_state_ff    <= nxt_trace;
            trace_loopback_ff <= nxt_loop;
            loop_reclock_ff   <= nxt_reclock;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_sleep_cable_dis: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st.sleep |=> cable_state_ff == osc_pkg::OSC_DISABLED) else $error("cable not disabled in sleep");
    a_sleep_trace: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st.sleep |=> trace_state_ff == ($past(trace_sleep_mute_ff) ? osc_pkg::OSC_MUTED : osc_pkg::OSC_DISABLED))
        else $error("trace sleep state wrong");
    a_balance_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st.sleep && cable_output_balance_ff) |=> cable_state_ff == osc_pkg::OSC_BALANCED)
        else $error("balance not applied");
    a_balance_trace: assert property (@(posedge clk_sys) disable iff (!rst_n)
        trace_state_ff != osc_pkg::OSC_BALANCED) else $error("trace balanced");
    a_auto_mute_los: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st.sleep && !cable_output_balance_ff && ctrl0.auto_mute && !ctrl0.auto_dis && !ctrl0.man_dis
         && st.loss_of_signal) |=> cable_state_ff == osc_pkg::OSC_MUTED) else $error("no mute on los");
    a_rate_mute: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st.sleep && !cable_output_balance_ff && ctrl0 == 5'h18
         && st.rate_search) |=> cable_state_ff == osc_pkg::OSC_MUTED) else $error("no mute on search");
    a_never_mute: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st.sleep && !cable_output_balance_ff && ctrl0 == '0) |=> cable_state_ff == osc_pkg::OSC_OPERATE)
        else $error("muted in never mode");
    a_dis_over_mute: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st.sleep && !cable_output_balance_ff && ctrl0.man_dis && !ctrl0.auto_dis && ctrl0.man_mute)
        |=> cable_state_ff == osc_pkg::OSC_DISABLED) else $error("disable lost to mute");
    a_loop_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
        trace_loopback_ff |-> $past(st.cable_mode) && trace_state_ff == osc_pkg::OSC_OPERATE)
        else $error("loopback outside cable mode");
    a_reclock_lock: assert property (@(posedge clk_sys) disable iff (!rst_n)
        loop_reclock_ff |-> trace_loopback_ff && $past(st.trace_locked)) else $error("reclock unlocked");
    a_idle_trace: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!st.sleep && st.cable_mode && !trace_loopback_enable_ff && ctrl1 == '0)
        |=> trace_state_ff == ($past(idle_trace_mute_select_ff) ? osc_pkg::OSC_MUTED : osc_pkg::OSC_DISABLED))
        else $error("idle trace wrong");

    c_loop: cover property (@(posedge clk_sys) disable iff (!rst_n) loop_reclock_ff);
    c_balanced: cover property (@(posedge clk_sys) disable iff (!rst_n) cable_state_ff == osc_pkg::OSC_BALANCED);
    c_sleep_mute: cover property (@(posedge clk_sys) disable iff (!rst_n)
        trace_state_ff == osc_pkg::OSC_MUTED && st.sleep);
endmodule : osc_top

// [verilog/osc_pkg.sv]
// Package with constants and types for the output state control block
// Behaviour
// - Each output has its own mute control with four selectable behaviours.
// - Auto mute bits in register 0x49 reset to one for both outputs.
// - Auto mute set: output mutes whenever loss of signal is asserted.
// - Auto mute plus rate-search bit: also mute while unlocked and searching.
// - Auto mute and forced mute both zero: output never muted.
// - Auto mute zero, forced mute one: output always muted.
// - Auto and forced disable bits in register 0x4A reset to zero.
// - Auto disable set: output disabled whenever loss of signal is asserted.
// - Auto disable zero, forced disable one: output always disabled.
// - Disable wins over mute when both apply.
// - Balance bit in 0x4D stops cable output toggling; trace output unaffected.
// - Balanced cable output overrides mute and disable.
// - Cable driver mode with loopback: trace output carries the trace input.
// - Cable mode without loopback: trace output muted or disabled per select bit.
// - Looped signal is re-clocked only while locked to the trace input.
// - Disable and mute take priority over loopback; balance does not affect it.
// - Loopback acts only in cable driver mode; otherwise the bit is ignored.
// - Sleep: cable disabled; trace disabled, or muted if sleep mute bit set.
package osc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, APB word registers)
    // ------------------------------------------------------------
    localparam logic [11:0] OSC_ADDR_MUTE    = 12'h049 << 2;
    localparam logic [11:0] OSC_ADDR_DISABLE = 12'h04A << 2;
    localparam logic [11:0] OSC_ADDR_BALANCE = 12'h04D << 2;
    localparam logic [11:0] OSC_ADDR_SLEEP   = 12'h005 << 2;
    localparam logic [11:0] OSC_ADDR_LOOP    = 12'h060 << 2;
    localparam logic [11:0] OSC_ADDR_STATUS  = 12'h061 << 2;

    // Field positions in mute register (per output n: base + n)
    localparam int OSC_B_AUTO_MUTE   = 0;
    localparam int OSC_B_RATE_MUTE   = 2;
    localparam int OSC_B_MAN_MUTE    = 4;
    // Disable register
    localparam int OSC_B_AUTO_DIS    = 0;
    localparam int OSC_B_MAN_DIS     = 2;
    // Balance, sleep and loop registers
    localparam int OSC_B_BALANCE     = 0;
    localparam int OSC_B_SLEEP_MUTE  = 0;
    localparam int OSC_B_LOOP_ENA    = 0;
    localparam int OSC_B_IDLE_MUTE   = 1;

    // Reset values
    localparam logic [5:0] OSC_RST_MUTE    = 6'h03;
    localparam logic [3:0] OSC_RST_DISABLE = 4'h0;
    localparam logic       OSC_RST_BAL     = 1'b0;
    localparam logic       OSC_RST_SLPMUTE = 1'b0;
    localparam logic [1:0] OSC_RST_LOOP    = 2'h0;

    // Output driver state
    typedef enum logic [1:0] {
        OSC_OPERATE,
        OSC_MUTED,
        OSC_DISABLED,
        OSC_BALANCED
    } osc_state_t;

    // Per-output control bits
    typedef struct packed {
        logic auto_mute;
        logic rate_mute;
        logic man_mute;
        logic auto_dis;
        logic man_dis;
    } osc_ctrl_t;

    // Synchronised device status
    typedef struct packed {
        logic loss_of_signal;
        logic rate_search;
        logic trace_locked;
        logic sleep;
        logic cable_mode;
    } osc_stat_t;

endpackage : osc_pkg

// [verilog/osc_sync.sv]
// Two-flop synchroniser for one status level
`timescale 1ns/1ps
module osc_sync (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_ff;

    // ------------------------------------------------------------
    // Sync chain
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            dout    <= 1'b0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule : osc_sync

// [verilog/osc_mode.sv]
// Mute and disable decision for one output
`timescale 1ns/1ps
module osc_mode (
    input  wire osc_pkg::osc_ctrl_t ctrl,
    input  wire logic               loss_of_signal,
    input  wire logic               rate_search,
    output osc_pkg::osc_state_t     state
);
    logic mute_req;
    logic dis_req;

    // Mute: auto on los or search, else manual
    assign mute_req = ctrl.auto_mute ? (loss_of_signal | (ctrl.rate_mute & rate_search))
                                     : ctrl.man_mute;
    // Disable: auto on los, else manual
    assign dis_req  = ctrl.auto_dis ? loss_of_signal : ctrl.man_dis;
    // Disable beats mute
    assign state    = dis_req  ? osc_pkg::OSC_DISABLED :
                      mute_req ? osc_pkg::OSC_MUTED : osc_pkg::OSC_OPERATE;
endmodule : osc_mode

// [testbench/osc_rx_model.sv]
// Downstream receiver model that reports whether the cable line carries data
`timescale 1ns/1ps
module osc_rx_model (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire osc_pkg::osc_state_t line_state,
    output logic                     link_up
);
    logic [1:0] run_ff;
    logic [1:0] nxt_run;

    // Count consecutive cycles of live data, saturating at three
    assign nxt_run = (line_state != osc_pkg::OSC_OPERATE) ? 2'h0 :
                     (run_ff == 2'h3) ? run_ff : run_ff + 2'h1;

    // Run counter register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 2'h0;
        end else begin
            run_ff <= nxt_run;
        end
    end

    // Receiver only claims lock after a few cycles of toggling data
    assign link_up = (run_ff == 2'h3);
endmodule : osc_rx_model

// [testbench/osc_top_tb.sv]
// Self-checking testbench for the output state control block
`timescale 1ns/1ps
module osc_top_tb;
    localparam logic [11:0] A_MUTE = osc_pkg::OSC_ADDR_MUTE;
    localparam logic [11:0] A_DIS  = osc_pkg::OSC_ADDR_DISABLE;
    localparam logic [11:0] A_BAL  = osc_pkg::OSC_ADDR_BALANCE;
    localparam logic [11:0] A_SLP  = osc_pkg::OSC_ADDR_SLEEP;
    localparam logic [11:0] A_LOOP = osc_pkg::OSC_ADDR_LOOP;
    localparam osc_pkg::osc_state_t S_OP  = osc_pkg::OSC_OPERATE;
    localparam osc_pkg::osc_state_t S_MU  = osc_pkg::OSC_MUTED;
    localparam osc_pkg::osc_state_t S_DI  = osc_pkg::OSC_DISABLED;
    localparam osc_pkg::osc_state_t S_BA  = osc_pkg::OSC_BALANCED;

    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic loss_of_signal, rate_search, trace_locked, sleep, cable_mode;
    logic trace_loopback_ff, loop_reclock_ff, cable_link_up, err;
    osc_pkg::osc_state_t cable_state_ff, trace_state_ff;
    int num_errors, num_checks;

    osc_top u_dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .loss_of_signal, .rate_search, .trace_locked, .sleep, .cable_mode, .cable_state_ff, .trace_state_ff,
        .trace_loopback_ff, .loop_reclock_ff);
    osc_rx_model u_rx (.clk_sys, .rst_n, .line_state(cable_state_ff), .link_up(cable_link_up));

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic chk_st(input string name, input osc_pkg::osc_state_t exp, input osc_pkg::osc_state_t got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_st
    task automatic exp2(input osc_pkg::osc_state_t c, input osc_pkg::osc_state_t t);
        chk_st("cable state", c, cable_state_ff);
        chk_st("trace state", t, trace_state_ff);
    endtask : exp2
    task automatic settle;
        repeat (4) @(posedge clk_sys);
    endtask : settle
    // One APB transfer; waits for pready, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    task automatic set_in(input logic l, input logic r, input logic k, input logic s, input logic c);
        loss_of_signal <= l;
        rate_search    <= r;
        trace_locked   <= k;
        sleep          <= s;
        cable_mode     <= c;
        settle();
    endtask : set_in

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_reset;
        apb(1'b0, A_MUTE, 32'h0);
        chk("mute reg", 32'h00000003, rd);
        chk("mute error", 32'h0, {31'h0, err});
        apb(1'b0, A_DIS, 32'h0);
        chk("disable reg", 32'h00000000, rd);
        exp2(S_OP, S_OP);
    endtask : t_reset
    task automatic t_mute;
        set_in(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        exp2(S_MU, S_MU);
        set_in(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        exp2(S_OP, S_OP);
        apb(1'b1, A_MUTE, 32'h00000005);
        settle();
        exp2(S_MU, S_OP);
        apb(1'b1, A_MUTE, 32'h00000020);
        set_in(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        exp2(S_OP, S_MU);
    endtask : t_mute
    task automatic t_dis;
        apb(1'b1, A_MUTE, 32'h00000003);
        apb(1'b1, A_DIS, 32'h00000001);
        settle();
        exp2(S_DI, S_MU);
        apb(1'b1, A_DIS, 32'h00000008);
        set_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        exp2(S_OP, S_DI);
        apb(1'b1, A_DIS, 32'h0000000C);
        apb(1'b1, A_MUTE, 32'h00000010);
        settle();
        exp2(S_DI, S_DI);
        apb(1'b1, A_BAL, 32'h00000001);
        settle();
        exp2(S_BA, S_DI);
        apb(1'b1, A_MUTE, 32'h00000003);
        apb(1'b1, A_DIS, 32'h00000000);
        apb(1'b1, A_BAL, 32'h00000000);
        settle();
        chk("receiver link", 32'h1, {31'h0, cable_link_up});
    endtask : t_dis
    task automatic t_loop;
        apb(1'b1, A_MUTE, 32'h00000001);
        set_in(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        exp2(S_OP, S_DI);
        apb(1'b1, A_LOOP, 32'h00000002);
        settle();
        exp2(S_OP, S_MU);
        apb(1'b1, A_LOOP, 32'h00000003);
        settle();
        exp2(S_OP, S_OP);
        chk("loopback", 32'h1, {31'h0, trace_loopback_ff});
        chk("reclock", 32'h0, {31'h0, loop_reclock_ff});
        set_in(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        chk("reclock", 32'h1, {31'h0, loop_reclock_ff});
        apb(1'b0, osc_pkg::OSC_ADDR_STATUS, 32'h0);
        chk("status reg", 32'h00000605, rd);
        chk("status error", 32'h0, {31'h0, err});
        apb(1'b1, A_MUTE, 32'h00000021);
        settle();
        chk_st("trace state", S_MU, trace_state_ff);
        chk("loopback", 32'h0, {31'h0, trace_loopback_ff});
        apb(1'b1, A_MUTE, 32'h00000003);
        set_in(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        exp2(S_OP, S_OP);
        chk("loopback", 32'h0, {31'h0, trace_loopback_ff});
    endtask : t_loop
    task automatic t_sleep;
        apb(1'b1, A_BAL, 32'h00000001);
        set_in(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        exp2(S_DI, S_DI);
        apb(1'b1, A_SLP, 32'h00000001);
        settle();
        exp2(S_DI, S_MU);
        apb(1'b0, 12'h3FC, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
    endtask : t_sleep

    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // -------------------------------------------------------------
    // Clock, watchdog and main sequence
    // -------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        num_errors++;
        report_and_stop();
    end
    initial begin
        num_errors = 0;
        num_checks = 0;
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {loss_of_signal, rate_search, trace_locked, sleep, cable_mode} = '0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_mute();
        t_dis();
        t_loop();
        t_sleep();
        report_and_stop();
    end
endmodule : osc_top_tb
